// *** hw/pcil_pkg.sv ***
package pcil_pkg;

  // ----------------------------------------------------------------
  // Bus commands
  // ----------------------------------------------------------------
  localparam logic [3:0] PCIL_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PCIL_CMD_MEM_WR = 4'h7;
  localparam logic [3:0] PCIL_CMD_CFG_RD = 4'hA;
  localparam logic [3:0] PCIL_CMD_CFG_WR = 4'hB;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [31:0] PCIL_BAR_BASE_DEF = 32'h4000_0000;
  localparam int PCIL_WIN_BITS_DEF = 24;
  localparam logic [31:0] PCIL_DATA_RST = 32'h0000_0000;
  localparam logic [3:0] PCIL_CBE_IDLE = 4'hF;
  // Link clock cycles of data phase without a device select claim.
  localparam logic [2:0] PCIL_DEVSEL_WAIT = 3'h5;

  // ----------------------------------------------------------------
  // Master status codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PCIL_ST_OK = 2'h0;
  localparam logic [1:0] PCIL_ST_RETRY = 2'h1;
  localparam logic [1:0] PCIL_ST_ABORT = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic idsel;
    logic master_grant_n;
  } pcil_bus_in_s;

  typedef struct packed {
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe_n;
    logic cbe_oe;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic trdy_n;
    logic trdy_oe;
    logic stop_n;
    logic stop_oe;
    logic devsel_n;
    logic devsel_oe;
    logic par;
    logic par_oe;
    logic master_request_n;
  } pcil_bus_out_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic write;
    logic cfg;
  } pcil_tgt_req_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic write;
  } pcil_mst_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic [1:0] status;
  } pcil_mst_rsp_s;

endpackage

// *** hw/pcil_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcil_sync (
  // Destination clock
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic d,
  output logic q
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q <= s3_reg;
      end
    end
  end

endmodule
`default_nettype wire

// *** hw/pcil_parity.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcil_parity (
  // Bus value
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  // Even parity bit
  output logic par
);

  // The pin makes the count of ones over the 36 bits and the pin itself even.
  assign par = ^{ad, cbe_n};

endmodule
`default_nettype wire

// *** hw/pcil_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcil_top #(
  parameter logic [31:0] BAR_BASE = pcil_pkg::PCIL_BAR_BASE_DEF,
  parameter int WIN_BITS = pcil_pkg::PCIL_WIN_BITS_DEF
) (
  // Clocks and reset
  input wire logic mclk,
  input wire logic pci_clk,
  input wire logic rst_n,
  // Bus pins
  input wire pcil_pkg::pcil_bus_in_s bus_in,
  output pcil_pkg::pcil_bus_out_s bus_out,
  // Target accesses handed to the core
  output logic tgt_req_valid,
  output pcil_pkg::pcil_tgt_req_s tgt_req,
  input wire logic tgt_done,
  input wire logic [31:0] tgt_rdata,
  // Master commands from the core
  input wire logic mst_start,
  input wire pcil_pkg::pcil_mst_req_s mst_cmd,
  output logic mst_busy,
  output logic mst_done,
  output pcil_pkg::pcil_mst_rsp_s mst_rsp
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (WIN_BITS < 2 || WIN_BITS > 31) begin : g_bad_win
    $error("WIN_BITS must lie between 2 and 31");
  end

  typedef enum logic [2:0] {
    T_IDLE,
    T_BUSY,
    T_CLAIM,
    T_WAIT,
    T_DATA,
    T_STOPW,
    T_BACKOFF
  } pcil_tstate_e;

  typedef enum logic [2:0] {
    M_IDLE,
    M_REQ,
    M_ADDR,
    M_DATA,
    M_TURN
  } pcil_mstate_e;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pcil_tstate_e t_state_reg;
  pcil_mstate_e m_state_reg;
  logic frame_prev_reg;
  logic treq_tgl_reg;
  logic tack_tgl_reg;
  logic treq_sync;
  logic tack_sync;
  logic [31:0] trdata_reg;
  logic t_ad_oe_reg;
  logic [31:0] t_ad_reg;
  logic t_trdy_n_reg;
  logic t_stop_n_reg;
  logic t_devsel_n_reg;
  logic t_sig_oe_reg;
  logic mreq_tgl_reg;
  logic mack_tgl_reg;
  logic mreq_sync;
  logic mack_sync;
  logic mack_seen_reg;
  pcil_pkg::pcil_mst_req_s mcmd_reg;
  pcil_pkg::pcil_mst_rsp_s mrsp_reg;
  logic [31:0] m_ad_reg;
  logic m_ad_oe_reg;
  logic [3:0] m_cbe_reg;
  logic m_own_oe_reg;
  logic m_frame_n_reg;
  logic m_irdy_n_reg;
  logic m_req_n_reg;
  logic [2:0] m_cnt_reg;
  logic par_reg;
  logic par_oe_reg;
  logic par_next;
  logic addr_phase;
  logic mem_hit;
  logic cfg_hit;
  logic m_active;
  logic [31:0] drv_ad;
  logic [3:0] par_cbe;

  // ----------------------------------------------------------------
  // Crossings between core and link clocks
  // ----------------------------------------------------------------
  pcil_sync u_treq_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .d(treq_tgl_reg),
    .q(treq_sync)
  );

  pcil_sync u_tack_sync (
    .clk(pci_clk),
    .rst_n(rst_n),
    .d(tack_tgl_reg),
    .q(tack_sync)
  );

  pcil_sync u_mreq_sync (
    .clk(pci_clk),
    .rst_n(rst_n),
    .d(mreq_tgl_reg),
    .q(mreq_sync)
  );

  pcil_sync u_mack_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .d(mack_tgl_reg),
    .q(mack_sync)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Master phases own the bus, so the device never answers itself.
  assign m_active = (m_state_reg == M_ADDR) || (m_state_reg == M_DATA) ||
                    (m_state_reg == M_TURN);
  assign addr_phase = !bus_in.frame_n && frame_prev_reg && !m_active;
  assign mem_hit = ((bus_in.cbe_n == pcil_pkg::PCIL_CMD_MEM_RD) ||
                    (bus_in.cbe_n == pcil_pkg::PCIL_CMD_MEM_WR)) &&
                   (bus_in.ad[31:WIN_BITS] == BAR_BASE[31:WIN_BITS]);
  assign cfg_hit = ((bus_in.cbe_n == pcil_pkg::PCIL_CMD_CFG_RD) ||
                    (bus_in.cbe_n == pcil_pkg::PCIL_CMD_CFG_WR)) &&
                   bus_in.idsel && (bus_in.ad[1:0] == 2'h0);

  always_ff @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_prev_reg <= 1'b1;
    end else begin
      frame_prev_reg <= bus_in.frame_n;
    end
  end

  // ----------------------------------------------------------------
  // Target state machine
  // ----------------------------------------------------------------
  // The request word is held still from the toggle until its answer,
  // so the core may read it across the clock boundary.
  always_ff @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_state_reg <= T_IDLE;
      tgt_req <= '0;
      treq_tgl_reg <= 1'b0;
      t_ad_reg <= pcil_pkg::PCIL_DATA_RST;
      t_ad_oe_reg <= 1'b0;
      t_trdy_n_reg <= 1'b1;
      t_stop_n_reg <= 1'b1;
      t_devsel_n_reg <= 1'b1;
      t_sig_oe_reg <= 1'b0;
    end else begin
      case (t_state_reg)
        T_IDLE: begin
          if (addr_phase) begin
            if (mem_hit || cfg_hit) begin
              tgt_req.addr <= bus_in.ad;
              tgt_req.write <= bus_in.cbe_n[0];
              tgt_req.cfg <= cfg_hit;
              t_devsel_n_reg <= 1'b0;
              t_trdy_n_reg <= 1'b1;
              t_stop_n_reg <= 1'b1;
              t_sig_oe_reg <= 1'b1;
              t_state_reg <= T_CLAIM;
            end else begin
              t_state_reg <= T_BUSY;
            end
          end
        end
        T_BUSY: begin
          if (bus_in.frame_n && bus_in.irdy_n) begin
            t_state_reg <= T_IDLE;
          end
        end
        T_CLAIM: begin
          if (!bus_in.irdy_n) begin
            tgt_req.be <= ~bus_in.cbe_n;
            tgt_req.wdata <= bus_in.ad;
            treq_tgl_reg <= ~treq_tgl_reg;
            t_state_reg <= T_WAIT;
          end
        end
        T_WAIT: begin
          if (tack_sync == treq_tgl_reg) begin
            if (!tgt_req.write) begin
              t_ad_reg <= trdata_reg;
              t_ad_oe_reg <= 1'b1;
            end
            t_trdy_n_reg <= 1'b0;
            // One phase per access: a burst is cut short at once.
            t_stop_n_reg <= bus_in.frame_n;
            t_state_reg <= T_DATA;
          end
        end
        T_DATA: begin
          if (!bus_in.irdy_n) begin
            t_trdy_n_reg <= 1'b1;
            t_ad_oe_reg <= 1'b0;
            if (!bus_in.frame_n) begin
              t_stop_n_reg <= 1'b0;
              t_state_reg <= T_STOPW;
            end else begin
              t_stop_n_reg <= 1'b1;
              t_devsel_n_reg <= 1'b1;
              t_state_reg <= T_BACKOFF;
            end
          end
        end
        T_STOPW: begin
          if (bus_in.frame_n) begin
            t_stop_n_reg <= 1'b1;
            t_devsel_n_reg <= 1'b1;
            t_state_reg <= T_BACKOFF;
          end
        end
        T_BACKOFF: begin
          t_sig_oe_reg <= 1'b0;
          t_state_reg <= T_IDLE;
        end
        default: begin
          t_state_reg <= T_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Target handshake, core side
  // ----------------------------------------------------------------
  assign tgt_req_valid = (treq_sync != tack_tgl_reg);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tack_tgl_reg <= 1'b0;
      trdata_reg <= pcil_pkg::PCIL_DATA_RST;
    end else if (tgt_done && tgt_req_valid) begin
      trdata_reg <= tgt_rdata;
      tack_tgl_reg <= ~tack_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // Master handshake, core side
  // ----------------------------------------------------------------
  assign mst_busy = (mreq_tgl_reg != mack_sync);
  assign mst_done = (mack_sync != mack_seen_reg);
  assign mst_rsp = mrsp_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mreq_tgl_reg <= 1'b0;
      mcmd_reg <= '0;
    end else if (mst_start && !mst_busy) begin
      mcmd_reg <= mst_cmd;
      mreq_tgl_reg <= ~mreq_tgl_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mack_seen_reg <= 1'b0;
    end else begin
      mack_seen_reg <= mack_sync;
    end
  end

  // ----------------------------------------------------------------
  // Master state machine
  // ----------------------------------------------------------------
  // Only single data phases are made, so frame rises with the
  // first assertion of initiator ready.
  always_ff @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_state_reg <= M_IDLE;
      mack_tgl_reg <= 1'b0;
      mrsp_reg <= '0;
      m_ad_reg <= pcil_pkg::PCIL_DATA_RST;
      m_ad_oe_reg <= 1'b0;
      m_cbe_reg <= pcil_pkg::PCIL_CBE_IDLE;
      m_own_oe_reg <= 1'b0;
      m_frame_n_reg <= 1'b1;
      m_irdy_n_reg <= 1'b1;
      m_req_n_reg <= 1'b1;
      m_cnt_reg <= 3'h0;
    end else begin
      case (m_state_reg)
        M_IDLE: begin
          if (mreq_sync != mack_tgl_reg) begin
            m_req_n_reg <= 1'b0;
            m_state_reg <= M_REQ;
          end
        end
        M_REQ: begin
          if (!bus_in.master_grant_n && bus_in.frame_n && bus_in.irdy_n &&
              (t_state_reg == T_IDLE)) begin
            m_ad_reg <= mcmd_reg.addr;
            m_ad_oe_reg <= 1'b1;
            m_cbe_reg <= mcmd_reg.write ? pcil_pkg::PCIL_CMD_MEM_WR :
                                         pcil_pkg::PCIL_CMD_MEM_RD;
            m_frame_n_reg <= 1'b0;
            m_own_oe_reg <= 1'b1;
            m_req_n_reg <= 1'b1;
            m_cnt_reg <= 3'h0;
            m_state_reg <= M_ADDR;
          end
        end
        M_ADDR: begin
          m_ad_reg <= mcmd_reg.wdata;
          m_ad_oe_reg <= mcmd_reg.write;
          m_cbe_reg <= ~mcmd_reg.be;
          m_frame_n_reg <= 1'b1;
          m_irdy_n_reg <= 1'b0;
          m_state_reg <= M_DATA;
        end
        M_DATA: begin
          m_cnt_reg <= m_cnt_reg + 3'h1;
          // Target lines are only looked at here, never driven.
          if (!bus_in.trdy_n) begin
            mrsp_reg.rdata <= bus_in.ad;
            mrsp_reg.status <= pcil_pkg::PCIL_ST_OK;
            m_state_reg <= M_TURN;
          end else if (!bus_in.stop_n) begin
            mrsp_reg.status <= pcil_pkg::PCIL_ST_RETRY;
            m_state_reg <= M_TURN;
          end else if (bus_in.devsel_n &&
                       (m_cnt_reg >= pcil_pkg::PCIL_DEVSEL_WAIT)) begin
            mrsp_reg.status <= pcil_pkg::PCIL_ST_ABORT;
            m_state_reg <= M_TURN;
          end
          if (!bus_in.trdy_n || !bus_in.stop_n ||
              (bus_in.devsel_n && (m_cnt_reg >= pcil_pkg::PCIL_DEVSEL_WAIT))) begin
            m_irdy_n_reg <= 1'b1;
            m_ad_oe_reg <= 1'b0;
            m_cbe_reg <= pcil_pkg::PCIL_CBE_IDLE;
          end
        end
        M_TURN: begin
          m_own_oe_reg <= 1'b0;
          mack_tgl_reg <= ~mack_tgl_reg;
          m_state_reg <= M_IDLE;
        end
        default: begin
          m_state_reg <= M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Parity, one link cycle behind the lines it covers
  // ----------------------------------------------------------------
  assign drv_ad = m_ad_oe_reg ? m_ad_reg : t_ad_reg;
  assign par_cbe = m_own_oe_reg ? m_cbe_reg : bus_in.cbe_n;

  pcil_parity u_parity (
    .ad(drv_ad),
    .cbe_n(par_cbe),
    .par(par_next)
  );

  always_ff @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_reg <= 1'b0;
      par_oe_reg <= 1'b0;
    end else begin
      par_reg <= par_next;
      par_oe_reg <= m_ad_oe_reg || t_ad_oe_reg;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign bus_out.ad = drv_ad;
  assign bus_out.ad_oe = m_ad_oe_reg || t_ad_oe_reg;
  assign bus_out.cbe_n = m_cbe_reg;
  assign bus_out.cbe_oe = m_own_oe_reg;
  assign bus_out.frame_n = m_frame_n_reg;
  assign bus_out.frame_oe = m_own_oe_reg;
  assign bus_out.irdy_n = m_irdy_n_reg;
  assign bus_out.irdy_oe = m_own_oe_reg;
  assign bus_out.trdy_n = t_trdy_n_reg;
  assign bus_out.trdy_oe = t_sig_oe_reg;
  assign bus_out.stop_n = t_stop_n_reg;
  assign bus_out.stop_oe = t_sig_oe_reg;
  assign bus_out.devsel_n = t_devsel_n_reg;
  assign bus_out.devsel_oe = t_sig_oe_reg;
  assign bus_out.par = par_reg;
  assign bus_out.par_oe = par_oe_reg;
  assign bus_out.master_request_n = m_req_n_reg;

endmodule
`default_nettype wire

// *** testbench/pcil_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcil_chk #(
  parameter logic [31:0] BAR_BASE = pcil_pkg::PCIL_BAR_BASE_DEF,
  parameter int WIN_BITS = pcil_pkg::PCIL_WIN_BITS_DEF
) (
  // Bus clock and reset
  input wire logic pci_clk,
  input wire logic rst_n,
  // Watched pins
  input wire pcil_pkg::pcil_bus_in_s bus_in,
  input wire pcil_pkg::pcil_bus_out_s bus_out,
  input wire pcil_pkg::pcil_tgt_req_s tgt_req
);
  // ------------------------------------------------------------
  // Decode of the address phase on the wire
  // ------------------------------------------------------------
  logic mem_hit;
  logic cfg_hit;
  logic own_bus;
  logic trdy_on;
  assign mem_hit = bus_in.cbe_n[3:1] == 3'h3 && bus_in.ad[31:WIN_BITS] == BAR_BASE[31:WIN_BITS];
  assign cfg_hit = bus_in.cbe_n[3:1] == 3'h5 && bus_in.idsel && bus_in.ad[1:0] == 2'h0;
  assign own_bus = bus_out.frame_oe || bus_out.irdy_oe;
  assign trdy_on = bus_out.trdy_oe && !bus_out.trdy_n;

  default clocking @(posedge pci_clk); endclocking
  default disable iff (!rst_n);

  chk_claim_hit: assert property ($fell(bus_in.frame_n) && !bus_out.frame_oe
    && (mem_hit || cfg_hit) |=> bus_out.devsel_oe && !bus_out.devsel_n)
    else $error("no claim on hit");
  chk_miss_quiet: assert property ($fell(bus_in.frame_n) && !bus_out.frame_oe
    && !mem_hit && !cfg_hit |=> !bus_out.devsel_oe [*4]) else $error("claim on miss");
  chk_trdy_data: assert property (trdy_on && !tgt_req.write |-> bus_out.ad_oe)
    else $error("ready without read data");
  chk_phase_end: assert property (trdy_on && !bus_in.irdy_n |=> bus_out.trdy_n)
    else $error("ready kept after phase");
  chk_par_even: assert property (bus_out.par_oe
    |-> bus_out.par == ^{$past(bus_in.ad), $past(bus_in.cbe_n)}) else $error("parity wrong");
  chk_stop_hold: assert property (trdy_on && !bus_in.frame_n
    |-> bus_out.stop_oe && !bus_out.stop_n) else $error("no stop on held frame");
  chk_devsel_park: assert property ($fell(bus_out.devsel_oe)
    |-> $past(bus_out.devsel_n)) else $error("select released active");
  chk_trdy_park: assert property ($fell(bus_out.trdy_oe)
    |-> $past(bus_out.trdy_n)) else $error("ready released active");
  chk_ad_float: assert property ((bus_in.frame_n && bus_in.irdy_n && !own_bus) [*3]
    |-> !bus_out.ad_oe) else $error("data lines driven when idle");
  chk_grant_first: assert property ($rose(bus_out.frame_oe)
    |-> !$past(bus_in.master_grant_n) && !bus_out.frame_n && bus_out.cbe_oe
    && bus_out.cbe_n[3:1] == 3'h3) else $error("bad master start");
  chk_master_quiet: assert property (own_bus
    |-> !bus_out.trdy_oe && !bus_out.stop_oe && !bus_out.devsel_oe)
    else $error("target lines driven as master");
  cov_ready: cover property (trdy_on);
  cov_stop: cover property (bus_out.stop_oe && !bus_out.stop_n);
  cov_master: cover property ($rose(bus_out.frame_oe));
endmodule
`default_nettype wire

// *** testbench/pcil_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcil_host_model #(
  parameter logic [31:0] RD_WORD = 32'h3C96_E1A5
) (
  // Bus clock and reset
  input wire logic pci_clk,
  input wire logic rst_n,
  // Pins seen from the far side
  input wire pcil_pkg::pcil_bus_out_s bus_out,
  output pcil_pkg::pcil_bus_in_s bus_in,
  // Answer to the device's accesses: 0 ready, 1 stop, 2 nobody claims
  input wire logic [1:0] mode,
  output logic [31:0] wcap
);
  logic [31:0] h_ad = 32'h0000_0000;
  logic [31:0] float_ad = 32'h5A5A_A5A5;
  logic [3:0] h_cbe_n = 4'hF;
  logic h_ad_oe = 1'b0;
  logic h_cbe_oe = 1'b0;
  logic h_frame_n = 1'b1;
  logic h_irdy_n = 1'b1;
  logic h_idsel = 1'b0;
  logic g_n = 1'b1;
  logic t_devsel_n = 1'b1;
  logic t_trdy_n = 1'b1;
  logic t_stop_n = 1'b1;
  logic t_ad_oe = 1'b0;
  logic t_rd = 1'b0;
  logic [1:0] st = 2'h0;

  // ------------------------------------------------------------
  // Wire levels
  // ------------------------------------------------------------
  // Controls idle high on pull-ups; floating data toggles so a stale value never passes.
  assign bus_in = '{
    ad: bus_out.ad_oe ? bus_out.ad : h_ad_oe ? h_ad : t_ad_oe ? RD_WORD : float_ad,
    cbe_n: bus_out.cbe_oe ? bus_out.cbe_n : h_cbe_oe ? h_cbe_n : float_ad[3:0],
    frame_n: bus_out.frame_oe ? bus_out.frame_n : h_frame_n,
    irdy_n: bus_out.irdy_oe ? bus_out.irdy_n : h_irdy_n,
    trdy_n: bus_out.trdy_oe ? bus_out.trdy_n : t_trdy_n,
    stop_n: bus_out.stop_oe ? bus_out.stop_n : t_stop_n,
    devsel_n: bus_out.devsel_oe ? bus_out.devsel_n : t_devsel_n,
    idsel: h_idsel,
    master_grant_n: g_n};
  always @(posedge pci_clk) float_ad <= ~bus_in.ad;

  // ------------------------------------------------------------
  // Target and arbiter for the device's own accesses
  // ------------------------------------------------------------
  always @(posedge pci_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= 2'h0;
    end else if (st == 2'h0) begin
      if (bus_out.frame_oe && !bus_out.frame_n && mode != 2'h2) begin
        st <= 2'h1;
        t_rd <= bus_out.cbe_n == pcil_pkg::PCIL_CMD_MEM_RD;
      end
    end else if (st == 2'h1) begin
      st <= 2'h2;
    end else if (!bus_out.irdy_n && !(t_trdy_n && t_stop_n)) begin
      st <= 2'h0;
      wcap <= bus_out.ad;
    end
  end

  always @(negedge pci_clk) begin
    g_n <= bus_out.master_request_n;
    t_devsel_n <= st == 2'h0;
    t_trdy_n <= !(st == 2'h2 && mode == 2'h0);
    t_stop_n <= !(st == 2'h2 && mode == 2'h1);
    t_ad_oe <= st == 2'h2 && t_rd;
  end

  // ------------------------------------------------------------
  // One access aimed at the device, single data phase
  // ------------------------------------------------------------
  task automatic access(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wdata,
      input logic [3:0] be, input logic sel, input logic hold, output logic claimed,
      output logic stopped, output logic done, output logic [31:0] rdata);
    claimed = 1'b0;
    done = 1'b0;
    @(negedge pci_clk);
    h_frame_n = 1'b0;
    h_ad = addr;
    h_ad_oe = 1'b1;
    h_cbe_n = cmd;
    h_cbe_oe = 1'b1;
    h_idsel = sel;
    @(negedge pci_clk);
    h_frame_n = !hold;
    h_irdy_n = 1'b0;
    h_ad = wdata;
    h_ad_oe = cmd[0];
    h_cbe_n = ~be;
    for (int n = 0; n < 400 && !done; n++) begin
      @(posedge pci_clk);
      claimed |= !bus_in.devsel_n;
      done = !bus_in.trdy_n;
      stopped = !bus_in.stop_n;
      rdata = bus_in.ad;
      if (n > 8 && !claimed) break;
    end
    @(negedge pci_clk);
    h_frame_n = 1'b1;
    h_irdy_n = 1'b1;
    h_ad_oe = 1'b0;
    h_cbe_oe = 1'b0;
    h_idsel = 1'b0;
    repeat (4) @(negedge pci_clk);
  endtask
endmodule
`default_nettype wire

// *** testbench/pcil_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] CORE_WORD = 32'hA5C3_0F96;
  localparam logic [31:0] MST_WORD = 32'h3C96_E1A5;
  logic mclk = 1'b0;
  logic pci_clk = 1'b0;
  logic rst_n = 1'b0;
  pcil_pkg::pcil_bus_in_s bus_in;
  pcil_pkg::pcil_bus_out_s bus_out;
  pcil_pkg::pcil_tgt_req_s tgt_req;
  pcil_pkg::pcil_tgt_req_s seen_req;
  pcil_pkg::pcil_mst_req_s mst_cmd = '0;
  pcil_pkg::pcil_mst_rsp_s mst_rsp;
  logic tgt_req_valid;
  logic tgt_done = 1'b0;
  logic answered = 1'b0;
  logic mst_start = 1'b0;
  logic mst_busy;
  logic mst_done;
  logic [1:0] mode = 2'h0;
  logic [31:0] wcap;
  int n_errors = 0;
  int check_count = 0;

  always #12.5 mclk = !mclk;
  // The bus clock is offset so its edges never line up with the core clock.
  initial begin
    #3.1;
    forever #7.5 pci_clk = !pci_clk;
  end

  pcil_top dut_u (.mclk(mclk), .pci_clk(pci_clk), .rst_n(rst_n), .bus_in(bus_in),
    .bus_out(bus_out), .tgt_req_valid(tgt_req_valid), .tgt_req(tgt_req), .tgt_done(tgt_done),
    .tgt_rdata(CORE_WORD), .mst_start(mst_start), .mst_cmd(mst_cmd), .mst_busy(mst_busy),
    .mst_done(mst_done), .mst_rsp(mst_rsp));
  pcil_host_model #(.RD_WORD(MST_WORD)) host_u (.pci_clk(pci_clk), .rst_n(rst_n),
    .bus_out(bus_out), .bus_in(bus_in), .mode(mode), .wcap(wcap));

  // Core answers each waiting access once.
  always @(negedge mclk) begin
    tgt_done <= tgt_req_valid && !answered;
    if (tgt_req_valid && !answered) seen_req <= tgt_req;
    answered <= tgt_req_valid;
  end

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic tgt(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wdata,
      input logic [3:0] be, input logic sel, input logic hold, input logic hit);
    logic claimed;
    logic stopped;
    logic done;
    logic [31:0] rdata;
    host_u.access(cmd, addr, wdata, be, sel, hold, claimed, stopped, done, rdata);
    check("claim", 32'(claimed), 32'(hit));
    if (hit) begin
      check("ready", 32'(done), 32'h1);
      if (done !== 1'b1) test_done();
      check("stop", 32'(stopped), 32'(hold));
      check("addr", seen_req.addr, addr);
      check("be", 32'(seen_req.be), 32'(be));
      check("write", 32'(seen_req.write), 32'(cmd[0]));
      check("cfg", 32'(seen_req.cfg), 32'(sel));
      check("data", cmd[0] ? seen_req.wdata : rdata, cmd[0] ? wdata : CORE_WORD);
    end
  endtask

  task automatic t_reset();
    check("oe", 32'({bus_out.ad_oe, bus_out.cbe_oe, bus_out.frame_oe, bus_out.irdy_oe,
      bus_out.trdy_oe, bus_out.stop_oe, bus_out.devsel_oe, bus_out.par_oe}), 32'h0);
    check("req", 32'(bus_out.master_request_n), 32'h1);
  endtask

  task automatic t_target();
    tgt(pcil_pkg::PCIL_CMD_MEM_WR, 32'h4000_0010, 32'h1234_5678, 4'h6, 1'b0, 1'b0, 1'b1);
    tgt(pcil_pkg::PCIL_CMD_MEM_RD, 32'h40FF_FFFC, 32'h0000_0000, 4'hF, 1'b0, 1'b0, 1'b1);
    tgt(pcil_pkg::PCIL_CMD_MEM_WR, 32'h4100_0000, 32'h0000_0001, 4'hF, 1'b0, 1'b0, 1'b0);
    tgt(pcil_pkg::PCIL_CMD_MEM_RD, 32'h3FFF_FFFC, 32'h0000_0000, 4'hF, 1'b0, 1'b0, 1'b0);
    tgt(pcil_pkg::PCIL_CMD_MEM_WR, 32'h4000_0100, 32'h8765_4321, 4'h9, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic t_config();
    for (int s = 0; s < 2; s++) begin
      tgt(pcil_pkg::PCIL_CMD_CFG_WR, 32'h0000_0010, 32'hF0E1_D2C3, 4'h3, s[0], 1'b0, s[0]);
      tgt(pcil_pkg::PCIL_CMD_CFG_RD, 32'h0000_0004, 32'h0000_0000, 4'hF, s[0], 1'b0, s[0]);
    end
  endtask

  task automatic mst(input logic write, input logic [1:0] how, input logic [1:0] exp);
    mode = how;
    @(negedge mclk);
    mst_start = 1'b1;
    mst_cmd = '{addr: 32'h8000_0040, wdata: 32'h0F1E_2D3C, be: 4'hF, write: write};
    @(negedge mclk);
    mst_start = 1'b0;
    check("busy", 32'(mst_busy), 32'h1);
    // The done pulse lasts one core cycle, so it is looked at mid-cycle where it stands settled.
    for (int n = 0; n < 400 && mst_done !== 1'b1; n++) @(negedge mclk);
    check("mdone", 32'(mst_done), 32'h1);
    if (mst_done !== 1'b1) test_done();
    check("idle", 32'(mst_busy), 32'h0);
    check("status", 32'(mst_rsp.status), 32'(exp));
    if (exp == pcil_pkg::PCIL_ST_OK) begin
      check("mdata", write ? wcap : mst_rsp.rdata, write ? 32'h0F1E_2D3C : MST_WORD);
    end
    repeat (4) @(negedge pci_clk);
  endtask

  task automatic t_master();
    mst(1'b1, 2'h0, pcil_pkg::PCIL_ST_OK);
    mst(1'b0, 2'h0, pcil_pkg::PCIL_ST_OK);
    mst(1'b0, 2'h1, pcil_pkg::PCIL_ST_RETRY);
    mst(1'b1, 2'h2, pcil_pkg::PCIL_ST_ABORT);
  endtask

  initial begin
    repeat (3) @(negedge mclk);
    t_reset();
    rst_n = 1'b1;
    repeat (3) @(negedge pci_clk);
    t_reset();
    t_target();
    t_config();
    t_master();
    t_target();
    test_done();
  end
endmodule

bind pcil_top pcil_chk #(.BAR_BASE(BAR_BASE), .WIN_BITS(WIN_BITS)) chk_u (.pci_clk(pci_clk),
  .rst_n(rst_n), .bus_in(bus_in), .bus_out(bus_out), .tgt_req(tgt_req));
`default_nettype wire
